// File: inc/sec_cmd_params.svh
// offsets, field positions, reset values and timing counts for the secondary command block
`ifndef SEC_CMD_PARAMS_SVH
`define SEC_CMD_PARAMS_SVH
// ============================================================
// register map (byte addresses)
`define SEC_CMD_OFFSET 8'h44
`define SEC_CTRL_OFFSET 8'h48
// ============================================================
// command field positions
`define CMD_IO_EN_BIT 0
`define CMD_MEM_EN_BIT 1
`define CMD_MASTER_EN_BIT 2
`define CMD_SPECIAL_BIT 3
`define CMD_MWI_BIT 4
`define CMD_SNOOP_BIT 5
`define CMD_PARITY_EN_BIT 6
`define CMD_WAIT_BIT 7
`define CMD_SERR_EN_BIT 8
`define CMD_FBB_BIT 9
`define CMD_INT_DIS_BIT 10
// writable bits of the command word
`define CMD_RW_MASK 16'h0547
`define CMD_RESET 16'h0000
// status bit for pending legacy interrupt, in the upper half of the word
`define STAT_INT_PEND_BIT 19
// ============================================================
// bus answer
`define UNMAPPED_READ 32'h0000_0000
`define READ_LATENCY 1
`endif

// File: inc/sec_cmd_pkg.sv
// types shared by the secondary command block
package sec_cmd_pkg;
	// bus slave states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK = 2'b01
	} bus_state_t;
	// bridge direction
	typedef enum logic {
		DIR_FORWARD = 1'b0,
		DIR_REVERSE = 1'b1
	} bridge_dir_t;
endpackage

// File: hdl/sec_cmd_reg.sv
// secondary interface command register with its gating of bridge actions
`timescale 1ns/100ps
`default_nettype none
`include "sec_cmd_params.svh"

module sec_cmd_reg
	import sec_cmd_pkg::*;
#(
	parameter int ADDR_W = 8 // byte address width
) (
	input wire logic clk_in, // bridge clock
	input wire logic rstn_in, // synchronous reset, active low
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] address_in, // byte address
	input wire logic read_in, // read request
	input wire logic write_in, // write request
	input wire logic [31:0] writedata_in, // write data
	input wire logic [3:0] byteenable_in, // byte lanes
	output logic [31:0] readdata_out, // read data
	output logic waitrequest_out, // stall until answer
	// bridge side
	input wire logic reverse_mode_in, // high for reverse bridge
	input wire logic sec_io_req_in, // i/o access seen on secondary
	input wire logic sec_mem_rd_req_in, // memory read seen on secondary
	input wire logic sec_mem_wr_req_in, // memory write seen on secondary
	input wire logic fwd_master_req_in, // forwarded cycle wants secondary master
	input wire logic parity_err_in, // parity error or poisoned packet, pulse
	input wire logic sys_err_in, // error condition, pulse
	input wire logic intx_req_in, // legacy interrupt level request
	output logic io_accept_out, // accept secondary i/o
	output logic mem_rd_accept_out, // accept secondary memory read
	output logic mem_wr_accept_out, // accept secondary memory write
	output logic master_grant_out, // may master forwarded cycle
	output logic special_accept_out, // special cycle target, never
	output logic mwi_origin_out, // originate invalidate writes, never
	output logic snoop_accept_out, // palette snoop, never
	output logic parity_flag_set_out, // set master data parity flag, pulse
	output logic err_msg_out, // forward: send error message, pulse
	output logic serr_drive_out, // reverse: system error pin driven
	output logic intx_assert_out, // legacy interrupt message asserted
	output logic fbb_en_out // fast back-to-back, never
);

	// ============================================================
	// elaboration checks
	generate
		if (ADDR_W < 8) begin : addr_w_check
			$error("ADDR_W too small for the register map");
		end
	endgenerate

	// ============================================================
	// state
	logic [15:0] cmd_r; // command word
	logic [15:0] cmd_nxt;
	logic [31:0] rdata_r; // read data
	logic [31:0] rdata_nxt;
	bus_state_t bus_r; // bus answer state
	bus_state_t bus_nxt;
	logic serr_r; // system error pin level
	logic serr_nxt;
	logic intx_r; // legacy interrupt message level
	logic intx_nxt;
	logic pend_r; // interrupt request pending
	logic pend_nxt;
	logic perr_r; // parity flag pulse
	logic perr_nxt;
	logic emsg_r; // error message pulse
	logic emsg_nxt;

	// decode of a byte address to the command word
	function automatic logic hit_cmd(input logic [ADDR_W-1:0] a);
		// zero-extended compare, also safe when the address is exactly one byte wide
		hit_cmd = (a == ADDR_W'(`SEC_CMD_OFFSET));
	endfunction

	// merge byte lanes of write data into a 16 bit word
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
			input logic [15:0] wd, input logic [1:0] be);
		lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// ============================================================
	// register bus: one wait cycle, then answer
	always_comb begin
		cmd_nxt = cmd_r;
		rdata_nxt = rdata_r;
		bus_nxt = bus_r;
		case (bus_r)
			BUS_IDLE: begin
				if (read_in || write_in) begin
					bus_nxt = BUS_ACK;
				end
			end
			BUS_ACK: begin
				// write takes effect here, read data was sampled in the idle cycle
				bus_nxt = BUS_IDLE;
			end
			default: begin
				bus_nxt = BUS_IDLE;
			end
		endcase
		if (bus_r == BUS_ACK && write_in && hit_cmd(address_in)) begin
			// write lands at the edge where waitrequest is seen low
			// only writable bits change, reserved and fixed bits stay zero
			cmd_nxt = lane_merge(cmd_r, writedata_in[15:0], byteenable_in[1:0])
				& `CMD_RW_MASK;
		end
		if (bus_r == BUS_IDLE && read_in) begin
			if (hit_cmd(address_in)) begin
				rdata_nxt = 32'h0000_0000;
				rdata_nxt[15:0] = cmd_r & `CMD_RW_MASK;
				rdata_nxt[`STAT_INT_PEND_BIT] = pend_r;
			end else begin
				rdata_nxt = `UNMAPPED_READ;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cmd_r <= `CMD_RESET;
			rdata_r <= 32'h0000_0000;
			bus_r <= BUS_IDLE;
		end else begin
			cmd_r <= cmd_nxt;
			rdata_r <= rdata_nxt;
			bus_r <= bus_nxt;
		end
	end

	assign readdata_out = rdata_r;
	// combinational stall, drops in the answer cycle only
	assign waitrequest_out = (read_in || write_in) && (bus_r != BUS_ACK);

	// ============================================================
	// transaction gating
	logic io_en; // i/o response enabled
	logic mem_en; // memory response enabled
	logic mst_en; // bus mastering enabled
	assign io_en = cmd_r[`CMD_IO_EN_BIT];
	assign mem_en = cmd_r[`CMD_MEM_EN_BIT];
	assign mst_en = cmd_r[`CMD_MASTER_EN_BIT];
	assign io_accept_out = sec_io_req_in && io_en && mst_en;
	assign mem_rd_accept_out = sec_mem_rd_req_in && mem_en && mst_en;
	assign mem_wr_accept_out = sec_mem_wr_req_in && mst_en;
	assign master_grant_out = fwd_master_req_in && mst_en;
	assign special_accept_out = 1'b0;
	assign mwi_origin_out = 1'b0;
	assign snoop_accept_out = 1'b0;
	assign fbb_en_out = 1'b0;

	// ============================================================
	// errors and legacy interrupt
	always_comb begin
		perr_nxt = parity_err_in && cmd_r[`CMD_PARITY_EN_BIT];
		emsg_nxt = !reverse_mode_in && sys_err_in && cmd_r[`CMD_SERR_EN_BIT];
		serr_nxt = reverse_mode_in && sys_err_in && cmd_r[`CMD_SERR_EN_BIT];
		pend_nxt = intx_req_in;
		// disable both blocks new messages and drops an asserted one
		intx_nxt = intx_req_in && !cmd_nxt[`CMD_INT_DIS_BIT];
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			perr_r <= 1'b0;
			emsg_r <= 1'b0;
			serr_r <= 1'b0;
			intx_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			perr_r <= perr_nxt;
			emsg_r <= emsg_nxt;
			serr_r <= serr_nxt;
			intx_r <= intx_nxt;
			pend_r <= pend_nxt;
		end
	end

	assign parity_flag_set_out = perr_r;
	assign err_msg_out = emsg_r;
	assign serr_drive_out = serr_r;
	assign intx_assert_out = intx_r;

	// ============================================================
	// assertions
	property p_io_gate;
		@(posedge clk_in) disable iff (!rstn_in)
		!cmd_r[`CMD_IO_EN_BIT] |-> !io_accept_out;
	endproperty
	a_io_gate: assert property (p_io_gate) else $error("i/o accepted while disabled");

	property p_mem_gate;
		@(posedge clk_in) disable iff (!rstn_in)
		!cmd_r[`CMD_MEM_EN_BIT] |-> !mem_rd_accept_out;
	endproperty
	a_mem_gate: assert property (p_mem_gate) else $error("memory read accepted");

	property p_mst_gate;
		@(posedge clk_in) disable iff (!rstn_in)
		!cmd_r[`CMD_MASTER_EN_BIT] |-> !(master_grant_out || mem_wr_accept_out);
	endproperty
	a_mst_gate: assert property (p_mst_gate) else $error("mastering while disabled");

	property p_fixed_zero;
		@(posedge clk_in) disable iff (!rstn_in)
		cmd_r[15:11] == 5'h00 && cmd_r[9] == 1'b0 && cmd_r[5:3] == 3'h0 && cmd_r[7] == 1'b0;
	endproperty
	a_fixed_zero: assert property (p_fixed_zero) else $error("fixed bit not zero");

	property p_parity;
		@(posedge clk_in) disable iff (!rstn_in)
		parity_err_in && cmd_r[`CMD_PARITY_EN_BIT] |=> parity_flag_set_out;
	endproperty
	a_parity: assert property (p_parity) else $error("parity flag not set");

	property p_err_msg;
		@(posedge clk_in) disable iff (!rstn_in)
		err_msg_out |-> $past(cmd_r[`CMD_SERR_EN_BIT]) && !$past(reverse_mode_in);
	endproperty
	a_err_msg: assert property (p_err_msg) else $error("error message while disabled");

	property p_serr;
		@(posedge clk_in) disable iff (!rstn_in)
		serr_drive_out |-> $past(cmd_r[`CMD_SERR_EN_BIT]) && $past(reverse_mode_in);
	endproperty
	a_serr: assert property (p_serr) else $error("system error driven while disabled");

	property p_int_release;
		@(posedge clk_in) disable iff (!rstn_in)
		$rose(cmd_r[`CMD_INT_DIS_BIT]) |-> !intx_assert_out;
	endproperty
	a_int_release: assert property (p_int_release) else $error("interrupt not released");

	property p_int_block;
		@(posedge clk_in) disable iff (!rstn_in)
		cmd_r[`CMD_INT_DIS_BIT] |-> !intx_assert_out;
	endproperty
	a_int_block: assert property (p_int_block) else $error("interrupt while disabled");

	// gates must open once their enables are set
	property p_io_open;
		@(posedge clk_in) disable iff (!rstn_in)
		sec_io_req_in && cmd_r[`CMD_IO_EN_BIT] && cmd_r[`CMD_MASTER_EN_BIT] |-> io_accept_out;
	endproperty
	a_io_open: assert property (p_io_open) else $error("enabled i/o not accepted");

	property p_mem_open;
		@(posedge clk_in) disable iff (!rstn_in)
		sec_mem_rd_req_in && cmd_r[`CMD_MEM_EN_BIT] && cmd_r[`CMD_MASTER_EN_BIT]
		|-> mem_rd_accept_out;
	endproperty
	a_mem_open: assert property (p_mem_open) else $error("enabled read not accepted");

	property p_mst_open;
		@(posedge clk_in) disable iff (!rstn_in)
		fwd_master_req_in && cmd_r[`CMD_MASTER_EN_BIT] |-> master_grant_out;
	endproperty
	a_mst_open: assert property (p_mst_open) else $error("enabled master not granted");

	property p_parity_quiet;
		@(posedge clk_in) disable iff (!rstn_in)
		!cmd_r[`CMD_PARITY_EN_BIT] |=> !parity_flag_set_out;
	endproperty
	a_parity_quiet: assert property (p_parity_quiet) else $error("parity flag while off");

	property p_fixed_outputs;
		@(posedge clk_in) disable iff (!rstn_in)
		!(special_accept_out || mwi_origin_out || snoop_accept_out || fbb_en_out);
	endproperty
	a_fixed_outputs: assert property (p_fixed_outputs) else $error("unsupported feature on");

	// readback and status
	property p_rdata_reserved;
		@(posedge clk_in) disable iff (!rstn_in)
		readdata_out[31:20] == 12'h000 && readdata_out[18:16] == 3'h0 && readdata_out[15:11] == 5'h00;
	endproperty
	a_rdata_reserved: assert property (p_rdata_reserved) else $error("reserved bit read high");

	property p_int_pending;
		@(posedge clk_in) disable iff (!rstn_in)
		bus_r == BUS_ACK && read_in && hit_cmd(address_in)
		|-> readdata_out[`STAT_INT_PEND_BIT] == $past(intx_req_in, 2);
	endproperty
	a_int_pending: assert property (p_int_pending) else $error("pending status wrong");

	property p_cmd_write;
		@(posedge clk_in) disable iff (!rstn_in)
		bus_r == BUS_ACK && write_in && hit_cmd(address_in) && byteenable_in[1:0] == 2'b11
		|=> cmd_r == ($past(writedata_in[15:0]) & `CMD_RW_MASK);
	endproperty
	a_cmd_write: assert property (p_cmd_write) else $error("command write lost");

endmodule
`default_nettype wire

// File: bench/sec_agent_model.sv
// model of the secondary-side bus agents that raise requests toward the bridge
`timescale 1ns/100ps
`default_nettype none
module sec_agent_model (
	input wire logic clk_in, // bridge clock
	input wire logic rstn_in, // reset, active low
	input wire logic [6:0] stim_in, // io, mem rd, mem wr, fwd, parity, error, intx
	output logic [6:0] drive_out // request lines toward the bridge
);
	// ============================================================
	// agent launch
	// agents act one edge after the bench asks, like a real bus turnaround
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			drive_out <= 7'h00; // quiet bus after reset
		end else begin
			drive_out <= stim_in; // a one-cycle ask gives a one-cycle pulse
		end
	end
endmodule
`default_nettype wire

// File: bench/sec_cmd_reg_test.sv
// self-checking bench for the secondary command register
`timescale 1ns/100ps
`default_nettype none
module sec_cmd_reg_test;
	// ============================================================
	// stimulus and observed signals
	logic clk_in = 1'b0; // bench clock
	logic rstn_in = 1'b0; // reset, active low
	logic [7:0] address_in = 8'h00; // bus address
	logic read_in = 1'b0; // bus read
	logic write_in = 1'b0; // bus write
	logic [31:0] writedata_in = 32'h0000_0000; // bus write data
	logic reverse_mode_in = 1'b0; // bridge direction
	logic [6:0] stim = 7'h00; // asks for the agent model
	logic [31:0] seed = 32'h0001_75ba; // xorshift state
	logic [31:0] expq[$]; // expected read data, oldest first
	int failures = 0; // mismatches
	int check_count = 0; // comparisons
	wire logic [6:0] drv; // agent request lines
	wire logic [31:0] rd; // read data
	wire logic wt, io_a, mr_a, mw_a, mg, sp, mwi, sn, pf, em, sd, ix, fbb; // design outputs
	sec_agent_model sec_agent_model_inst (.clk_in(clk_in), .rstn_in(rstn_in), .stim_in(stim),
		.drive_out(drv));
	sec_cmd_reg sec_cmd_reg_inst (.clk_in(clk_in), .rstn_in(rstn_in), .address_in(address_in),
		.read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
		.byteenable_in(4'h3), .readdata_out(rd), .waitrequest_out(wt),
		.reverse_mode_in(reverse_mode_in), .sec_io_req_in(drv[0]), .sec_mem_rd_req_in(drv[1]),
		.sec_mem_wr_req_in(drv[2]), .fwd_master_req_in(drv[3]), .parity_err_in(drv[4]),
		.sys_err_in(drv[5]), .intx_req_in(drv[6]), .io_accept_out(io_a),
		.mem_rd_accept_out(mr_a), .mem_wr_accept_out(mw_a), .master_grant_out(mg),
		.special_accept_out(sp), .mwi_origin_out(mwi), .snoop_accept_out(sn),
		.parity_flag_set_out(pf), .err_msg_out(em), .serr_drive_out(sd),
		.intx_assert_out(ix), .fbb_en_out(fbb));
	// ============================================================
	// helpers
	// clock generator, 10 ns period
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	// pseudo-random source
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// one comparison
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic complete_run();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// one bus cycle: raised after a rising edge, held until waitrequest is seen low there
	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
		input logic [31:0] exp);
		int n;
		n = 0;
		@(posedge clk_in);
		if (!wr) expq.push_back(exp);
		address_in <= a;
		writedata_in <= {16'h0000, d};
		write_in <= wr;
		read_in <= !wr;
		do begin
			@(posedge clk_in);
			n++;
		end while (wt !== 1'b0 && n < 50);
		if (n >= 50) failures++;
		write_in <= 1'b0;
		read_in <= 1'b0;
	endtask
	// read data monitor, compares against the oldest note
	always @(posedge clk_in) begin
		if (read_in === 1'b1 && wt === 1'b0 && expq.size() > 0) begin
			check(rd, expq.pop_front());
		end
	end
	// watchdog
	initial begin
		#200000;
		failures++;
		complete_run();
	end
	// ============================================================
	// main sequence
	initial begin
		int i;
		logic [15:0] v;
		repeat (4) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		// reset value, then read-only and reserved bits ignore writes
		bus(1'b0, 8'h44, 16'h0000, 32'h0000_0000);
		bus(1'b1, 8'h44, 16'hffff, 32'h0000_0000);
		bus(1'b0, 8'h44, 16'h0000, 32'h0000_0547);
		bus(1'b1, 8'h48, 16'hffff, 32'h0000_0000);
		bus(1'b0, 8'h48, 16'h0000, 32'h0000_0000);
		$display("register access test done");
		// gating of secondary requests by random enables
		stim <= 7'h0f;
		for (i = 0; i < 8; i++) begin
			v = 16'(xs()) & 16'h0547;
			bus(1'b1, 8'h44, v, 32'h0000_0000);
			bus(1'b0, 8'h44, 16'h0000, {16'h0000, v});
			@(negedge clk_in);
			check(32'({sp, mwi, sn, fbb, mg, mw_a, mr_a, io_a}),
				32'({4'h0, v[2], v[2], v[1] & v[2], v[0] & v[2]}));
		end
		stim <= 7'h00;
		$display("request gating test done");
		// parity and error reporting in both directions
		for (i = 0; i < 8; i++) begin
			v = 16'({i[2], 1'b0, i[1], 6'h00});
			bus(1'b1, 8'h44, v, 32'h0000_0000);
			reverse_mode_in <= i[0];
			stim <= 7'h30;
			@(posedge clk_in);
			stim <= 7'h00;
			@(posedge clk_in);
			@(negedge clk_in);
			check(32'({pf, em, sd}), 32'({v[6], v[8] & !i[0], v[8] & i[0]}));
		end
		$display("error reporting test done");
		// legacy interrupt, status, then disable releases it
		bus(1'b1, 8'h44, 16'h0000, 32'h0000_0000);
		stim <= 7'h40;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		check(32'(ix), 32'h0000_0001);
		bus(1'b0, 8'h44, 16'h0000, 32'h0008_0000);
		bus(1'b1, 8'h44, 16'h0400, 32'h0000_0000);
		@(negedge clk_in);
		check(32'(ix), 32'h0000_0000);
		bus(1'b0, 8'h44, 16'h0000, 32'h0008_0400);
		bus(1'b1, 8'h44, 16'h0000, 32'h0000_0000);
		@(negedge clk_in);
		check(32'(ix), 32'h0000_0001);
		$display("interrupt test done");
		complete_run();
	end
endmodule
`default_nettype wire
